// ### pkg/acg_params.svh
// Constants of the audio clock generator: field positions, ratio limits, scalings
`ifndef ACG_PARAMS_SVH
`define ACG_PARAMS_SVH

// --------------------------------------------------------------------------
// Clock source register and its fields
// --------------------------------------------------------------------------
`define ACG_SRC_REG_IDX      8'd102
`define ACG_DIVSRC_LSB       6
`define ACG_LOOPSRC_LSB      4

// --------------------------------------------------------------------------
// Clock ratios
// --------------------------------------------------------------------------
`define ACG_MCLK_RATIO       32'd256
`define ACG_BYPASS_DIV       32'd128
`define ACG_LOOP_DIV         32'd2048
`define ACG_FRAC_SCALE       32'd10000
`define ACG_CO_GAIN          32'd4
`define ACG_FSREF_LAST       8'hff

// --------------------------------------------------------------------------
// Legal ranges of the programmable ratios
// --------------------------------------------------------------------------
`define ACG_Q_MIN            32'd2
`define ACG_Q_MAX            32'd17
`define ACG_P_MIN            32'd1
`define ACG_P_MAX            32'd8
`define ACG_R_MIN            32'd1
`define ACG_R_MAX            32'd16
`define ACG_J_MIN            32'd1
`define ACG_J_MAX            32'd63
`define ACG_D_MAX            32'd9999
`define ACG_N_MIN            32'd2
`define ACG_N_MAX            32'd17
`define ACG_HALF_MIN         32'd2
`define ACG_HALF_MAX         32'd12

// --------------------------------------------------------------------------
// Frequencies in kHz
// --------------------------------------------------------------------------
`define ACG_CLK_KHZ          32'd25000
`define ACG_MCLK_MIN_KHZ     32'd512
`define ACG_MCLK_MAX_KHZ     32'd50000
`define ACG_PIN_MAX_KHZ      (`ACG_CLK_KHZ / 32'd2)

`endif

// ### pkg/acg_pkg.sv
// Types shared by the audio clock generator modules
package acg_pkg;

  // Clock source codes of the two select fields
  typedef enum logic [1:0] {
    ACG_SRC_MCLK = 2'h0,
    ACG_SRC_GP2  = 2'h1,
    ACG_SRC_BCLK = 2'h2
  } acg_src_t;

  // Ratio and mode settings driven by the control logic
  typedef struct packed {
    logic        pll_en;
    logic [4:0]  q;
    logic [3:0]  p;
    logic [4:0]  r;
    logic [5:0]  j;
    logic [13:0] d;
    logic [1:0]  m_sel;
    logic [4:0]  n;
    logic        clkout_mux;
    logic        clkout_en;
    logic [3:0]  adc_half;
    logic [3:0]  dac_half;
    logic        adc_dual;
    logic        dac_dual;
    logic        conv_pd;
  } acg_cfg_t;

endpackage : acg_pkg

// ### hw/acg_ratio_div.sv
// Fractional rate divider: emits add/thr ticks per input event on average
`timescale 1ns/1ns
`include "acg_params.svh"
module acg_ratio_div
  import acg_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  // Input events and rate setting
  input  wire logic        event_in,
  input  wire logic [31:0] add_in,
  input  wire logic [31:0] thr_in,
  // Output pulse
  output logic             tick_out
);

  logic [31:0] credit_reg;
  logic [31:0] credit_next;
  logic        tick_reg;
  logic        tick_next;
  logic [32:0] sum;
  logic        fire;

  // --------------------------------------------------------------------------
  // Credit bucket
  // --------------------------------------------------------------------------
  // Saturate rather than wrap, so an over-fast source loses only the credit above the top
  always_comb
  begin
    sum         = {1'b0, credit_reg} + {1'b0, (event_in ? add_in : 32'h0000_0000)};
    fire        = (thr_in != 32'h0000_0000) && (credit_reg >= thr_in);
    credit_next = (sum[32] ? 32'hffff_ffff : sum[31:0]) - (fire ? thr_in : 32'h0000_0000);
    tick_next   = fire;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      credit_reg <= 32'h0000_0000;
      tick_reg   <= 1'b0;
    end
    else
    begin
      credit_reg <= credit_next;
      tick_reg   <= tick_next;
    end
  end

  assign tick_out = tick_reg;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  tick_has_credit_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    tick_out |-> ($past(credit_reg) >= $past(thr_in)) && ($past(thr_in) != 32'h0000_0000))
    else $error("tick without enough credit");

  credit_drains_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (fire && !event_in) |=> (credit_reg == $past(credit_reg) - $past(thr_in)))
    else $error("credit not reduced by threshold");

endmodule : acg_ratio_div

// ### hw/acg_clock_gen.sv
// Audio clock generator: converter master clock, reference rate, clock out pin
`timescale 1ns/1ns
`include "acg_params.svh"

// Operation
// - The converter master clock runs at 256 times the reference sample rate, from an outside clock.
// - With the loop off, the reference rate is the divider source over 128 times Q, Q from 2 to 17.
// - Bits 7 to 6 of the source register pick the divider source: master, bit clock or second pin.
// - With the loop on, the reference rate is source times K times R over 2048 times P.
// - K is an integer part 1 to 63 plus a four-digit decimal fraction 0000 to 9999.
// - Bits 5 to 4 of the source register pick the loop source: master, bit clock, or second pin while the converters are down.
// - With the converters down, a clock on the second pin may pass the loop out to the first pin.
// - With output select 0 and the loop on, the first pin runs at source times 2KR over M N P.
// - With output select 1, the first pin runs at the divider source times 2 over M times N.
// - Converter rates are the reference rate, or twice it, over a half-step ratio from 1 to 6.
module acg_clock_gen
  import acg_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  // Clock pins from outside
  input  wire logic       master_clk_pin_in,
  input  wire logic       bit_clk_pin_in,
  input  wire logic       second_general_pin_in,
  // Settings
  input  wire logic [7:0] clk_src_reg_in,
  input  wire acg_cfg_t   cfg_in,
  // Internal clock events
  output logic            conv_mclk_tick_out,
  output logic            fsref_tick_out,
  output logic            adc_rate_tick_out,
  output logic            dac_rate_tick_out,
  // Clock output pin and loop status
  output logic            first_general_pin_out,
  output logic            first_general_pin_oe_out,
  output logic            loop_active_out
);

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  // Clamp a setting into its legal range
  function automatic logic [31:0] clampv(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    clampv = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clampv

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Pins above half of mclk_in alias; this model sees at most 12.5 MHz
  logic [2:0] sync1_reg, sync1_next;
  logic [2:0] sync2_reg, sync2_next;
  logic [2:0] hist_reg,  hist_next;
  logic [2:0] pin_edge;
  logic       mclk_edge, bclk_edge, gp2_edge;

  always_comb
  begin
    sync1_next = {second_general_pin_in, bit_clk_pin_in, master_clk_pin_in};
    sync2_next = sync1_reg;
    hist_next  = sync2_reg;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      hist_reg  <= 3'h0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      hist_reg  <= hist_next;
    end
  end

  assign pin_edge  = sync2_reg & ~hist_reg;
  assign mclk_edge = pin_edge[0];
  assign bclk_edge = pin_edge[1];
  assign gp2_edge  = pin_edge[2];

  // --------------------------------------------------------------------------
  // Source selection and ratio arithmetic
  // --------------------------------------------------------------------------
  acg_src_t    div_sel, loop_sel;
  logic        divider_source_clock, loop_source_clock;
  logic [31:0] q, p, r, j, d, n, m, k_scaled;
  logic [31:0] master_add, master_thr, co_add, co_thr;
  logic        master_event, co_event;

  always_comb
  begin
    div_sel  = acg_src_t'(clk_src_reg_in[`ACG_DIVSRC_LSB +: 2]);
    loop_sel = acg_src_t'(clk_src_reg_in[`ACG_LOOPSRC_LSB +: 2]);
    // Divider source: master pin, bit clock or second pin
    unique case (div_sel)
      ACG_SRC_GP2:  divider_source_clock = gp2_edge;
      ACG_SRC_BCLK: divider_source_clock = bclk_edge;
      default:      divider_source_clock = mclk_edge;
    endcase
    // Second pin feeds the loop only while the converters are down
    unique case (loop_sel)
      ACG_SRC_BCLK: loop_source_clock = bclk_edge;
      ACG_SRC_GP2:  loop_source_clock = cfg_in.conv_pd ? gp2_edge : mclk_edge;
      default:      loop_source_clock = mclk_edge;
    endcase
    q = clampv(32'(cfg_in.q), `ACG_Q_MIN, `ACG_Q_MAX);
    p = clampv(32'(cfg_in.p), `ACG_P_MIN, `ACG_P_MAX);
    r = clampv(32'(cfg_in.r), `ACG_R_MIN, `ACG_R_MAX);
    j = clampv(32'(cfg_in.j), `ACG_J_MIN, `ACG_J_MAX);
    d = clampv(32'(cfg_in.d), 32'h0000_0000, `ACG_D_MAX);
    n = clampv(32'(cfg_in.n), `ACG_N_MIN, `ACG_N_MAX);
    m = 32'h0000_0001 << cfg_in.m_sel;
    // Multiplier kept as K times ten thousand
    k_scaled = j * `ACG_FRAC_SCALE + d;
    // Master ticks per source edge: K R / (8 P) with the loop, 2 / Q without
    master_event = cfg_in.pll_en ? loop_source_clock : divider_source_clock;
    if (cfg_in.conv_pd)
      master_add = 32'h0000_0000;
    else if (cfg_in.pll_en)
      master_add = k_scaled * r;
    else
      master_add = `ACG_MCLK_RATIO / `ACG_BYPASS_DIV;
    master_thr = cfg_in.pll_en ? (`ACG_LOOP_DIV / `ACG_MCLK_RATIO) * p * `ACG_FRAC_SCALE : q;
    // Pin toggles once per tick, hence the factor of four
    if (!cfg_in.clkout_mux)
    begin
      co_event = loop_source_clock;
      co_add   = cfg_in.pll_en ? k_scaled * r * `ACG_CO_GAIN : 32'h0000_0000;
      co_thr   = p * `ACG_FRAC_SCALE * m * n;
    end
    else
    begin
      co_event = divider_source_clock;
      co_add   = `ACG_CO_GAIN;
      co_thr   = m * n;
    end
  end

  // --------------------------------------------------------------------------
  // Master clock and clock output dividers
  // --------------------------------------------------------------------------
  logic master_tick, co_tick;

  acg_ratio_div u_master_div (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .event_in (master_event),
    .add_in   (master_add),
    .thr_in   (master_thr),
    .tick_out (master_tick)
  );

  acg_ratio_div u_clkout_div (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .event_in (co_event),
    .add_in   (co_add),
    .thr_in   (co_thr),
    .tick_out (co_tick)
  );

  // --------------------------------------------------------------------------
  // Reference rate counter and clock output pin
  // --------------------------------------------------------------------------
  logic [7:0] mcnt_reg, mcnt_next;
  logic       fsref_reg, fsref_next;
  logic       pin_reg, pin_next;

  always_comb
  begin
    mcnt_next  = master_tick ? mcnt_reg + 8'h01 : mcnt_reg;
    fsref_next = master_tick && (mcnt_reg == `ACG_FSREF_LAST);
    pin_next   = (co_tick && cfg_in.clkout_en) ? !pin_reg : pin_reg;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mcnt_reg  <= 8'h00;
      fsref_reg <= 1'b0;
      pin_reg   <= 1'b0;
    end
    else
    begin
      mcnt_reg  <= mcnt_next;
      fsref_reg <= fsref_next;
      pin_reg   <= pin_next;
    end
  end

  // --------------------------------------------------------------------------
  // Converter rate dividers, one per converter
  // --------------------------------------------------------------------------
  logic [1:0] rate_tick;
  logic [3:0] half_sel [2];
  logic [1:0] dual_sel;

  assign half_sel[0] = cfg_in.adc_half;
  assign half_sel[1] = cfg_in.dac_half;
  assign dual_sel    = {cfg_in.dac_dual, cfg_in.adc_dual};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_rate
      // Ratio is held doubled so half steps stay integers
      acg_ratio_div u_rate_div (
        .mclk_in  (mclk_in),
        .rst_b_in (rst_b_in),
        .event_in (fsref_reg),
        .add_in   (dual_sel[ch] ? 32'h0000_0004 : 32'h0000_0002),
        .thr_in   (clampv(32'(half_sel[ch]), `ACG_HALF_MIN, `ACG_HALF_MAX)),
        .tick_out (rate_tick[ch])
      );
    end
  endgenerate

  assign conv_mclk_tick_out       = master_tick;
  assign fsref_tick_out           = fsref_reg;
  assign adc_rate_tick_out        = rate_tick[0];
  assign dac_rate_tick_out        = rate_tick[1];
  assign first_general_pin_out    = pin_reg;
  assign first_general_pin_oe_out = cfg_in.clkout_en;
  assign loop_active_out          = cfg_in.pll_en;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_co_tick;
    co_tick && cfg_in.clkout_en;
  endsequence

  sequence s_pin_flip;
    first_general_pin_out != $past(first_general_pin_out);
  endsequence

  fsref_every_256_a: assert property (
    fsref_tick_out |-> ($past(mcnt_reg) == 8'hff) && $past(master_tick) && (mcnt_reg == 8'h00))
    else $error("reference tick not on 256th master tick");
  bypass_ratio_a: assert property (
    (!cfg_in.pll_en && !cfg_in.conv_pd) |-> (master_add == 32'd2) && (master_thr == q) && (q >= 32'd2))
    else $error("bypass ratio wrong");
  div_source_a: assert property (
    (clk_src_reg_in[7:6] == 2'h2) |-> (divider_source_clock == bclk_edge))
    else $error("divider source select wrong");
  loop_ratio_a: assert property (
    cfg_in.pll_en |-> (master_thr == p * 32'd80000))
    else $error("loop threshold wrong");
  frac_mult_a: assert property (
    (cfg_in.j == 6'd7 && cfg_in.d == 14'd5264) |-> (k_scaled == 32'd75264))
    else $error("multiplier assembly wrong");
  loop_source_a: assert property (
    (clk_src_reg_in[5:4] == 2'h2) |-> (loop_source_clock == bclk_edge))
    else $error("loop source select wrong");
  passthru_a: assert property (
    (cfg_in.conv_pd && clk_src_reg_in[5:4] == 2'h1) |-> (loop_source_clock == gp2_edge) && (master_add == 32'd0))
    else $error("second pin not routed through loop");
  pin_follows_a: assert property (
    s_co_tick |=> s_pin_flip)
    else $error("clock out pin did not toggle");
  direct_out_a: assert property (
    cfg_in.clkout_mux |-> (co_add == 32'd4) && (co_thr == m * n) && (co_event == divider_source_clock))
    else $error("direct clock out ratio wrong");
  rate_gap_a: assert property (
    adc_rate_tick_out |-> $past(fsref_tick_out, 2) || $past(fsref_tick_out, 3))
    else $error("converter rate tick away from reference tick");

endmodule : acg_clock_gen

// ### sim/acg_src_model.sv
// Outside clock sources feeding the master, second general and bit clock pins
`timescale 1ns/1ns
module acg_src_model
#(
  parameter int HALF0 = 160,
  parameter int HALF1 = 200,
  parameter int HALF2 = 240
)
(
  // Run enables: master, second general, bit clock
  input  wire logic [2:0] run_in,
  // Pin clocks in the same order
  output logic      [2:0] pin_out
);
  // Each pin stands still low between bursts; a burst ends on a whole period
  for (genvar g = 0; g < 3; g++)
  begin : gen_pin
    localparam int H = (g == 0) ? HALF0 : (g == 1) ? HALF1 : HALF2;
    initial
    begin
      pin_out[g] = 1'b0;
      forever
      begin
        wait (run_in[g]);
        pin_out[g] = 1'b1;
        #H;
        pin_out[g] = 1'b0;
        #H;
      end
    end
  end
endmodule : acg_src_model

// ### sim/acg_clock_gen_tb.sv
// Self-checking bench of the audio clock generator
`timescale 1ns/1ns
module acg_clock_gen_tb
  import acg_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------------
  logic       mclk_in;
  logic       rst_b_in = 1'b0;
  logic [2:0] run = 3'h0;
  logic [2:0] pins;
  logic [7:0] clk_src_reg = 8'h00;
  acg_cfg_t   cfg = '0;
  acg_cfg_t   c;
  acg_cfg_t   base;
  logic       conv_mclk_tick_out, fsref_tick_out, adc_rate_tick_out, dac_rate_tick_out;
  logic       first_general_pin_out, first_general_pin_oe_out, loop_active_out;
  logic       pin_prev;
  int         err_total = 0;
  int         checks    = 0;
  int         seed      = 32'h69cc84ea;
  int         cycles    = 0;
  int         cnt [5];
  int         e [3];
  bit         counting  = 1'b0;
  longint     mc, fs;

  acg_clock_gen acg_clock_gen_i (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .master_clk_pin_in(pins[0]),
    .bit_clk_pin_in(pins[2]), .second_general_pin_in(pins[1]),
    .clk_src_reg_in(clk_src_reg), .cfg_in(cfg),
    .conv_mclk_tick_out(conv_mclk_tick_out), .fsref_tick_out(fsref_tick_out),
    .adc_rate_tick_out(adc_rate_tick_out), .dac_rate_tick_out(dac_rate_tick_out),
    .first_general_pin_out(first_general_pin_out),
    .first_general_pin_oe_out(first_general_pin_oe_out), .loop_active_out(loop_active_out));

  acg_src_model acg_src_model_i (.run_in(run), .pin_out(pins));

  // 25 MHz system clock
  initial
  begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  // Source edges seen during a window
  always @(posedge pins[0]) if (counting) e[0]++;
  always @(posedge pins[1]) if (counting) e[1]++;
  always @(posedge pins[2]) if (counting) e[2]++;

  // Sample outputs on the falling edge, away from the flops' updates
  always @(negedge mclk_in)
  begin
    cycles++;
    if (counting)
    begin
      cnt[0] += (conv_mclk_tick_out === 1'b1);
      cnt[1] += (fsref_tick_out === 1'b1);
      cnt[2] += (adc_rate_tick_out === 1'b1);
      cnt[3] += (dac_rate_tick_out === 1'b1);
      cnt[4] += (first_general_pin_out === 1'b1 && pin_prev === 1'b0);
    end
    pin_prev = first_general_pin_out;
    // Ceiling well above the run length of all tests
    if (cycles == 90000)
    begin
      err_total++;
      wrap_up();
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic int rnd(input int lo, input int hi);
    return lo + int'($unsigned($random(seed)) % (hi - lo + 1));
  endfunction : rnd

  // Whole ticks owed for e events at num/den each; credit remainder stays
  function automatic longint scale(input longint ev, input longint num, input longint den);
    return (ev * num) / den;
  endfunction : scale

  // Counts may differ by one where a window cuts a credit; zero is exact
  task automatic check_cnt(input string name, input longint exp, input int got);
    checks++;
    if (got < exp - (exp != 0) || got > exp + (exp != 0))
    begin
      err_total++;
      $display("ERROR %s expected %0d seen %0d", name, exp, got);
    end
  endtask : check_cnt

  task automatic check_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  // Reset clears credits so each window starts from nothing
  task automatic run_test(input logic [7:0] src, input acg_cfg_t s, input int ncyc);
    @(posedge mclk_in);
    #1;
    rst_b_in = 1'b0;
    clk_src_reg = src;
    cfg = s;
    repeat (2) @(posedge mclk_in);
    #1;
    rst_b_in = 1'b1;
    cnt = '{default: 0};
    e = '{default: 0};
    counting = 1'b1;
    run = 3'h7;
    repeat (ncyc) @(posedge mclk_in);
    #1;
    run = 3'h0;
    repeat (60) @(posedge mclk_in);
    counting = 1'b0;
    check_bit("loop_active", s.pll_en, loop_active_out);
    check_bit("clkout_oe", s.clkout_en, first_general_pin_oe_out);
  endtask : run_test

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    base = '0;
    base.q = 5'd2;
    base.p = 4'd1;
    base.r = 5'd1;
    base.j = 6'd1;
    base.n = 5'd2;
    base.adc_half = 4'd2;
    base.dac_half = 4'd2;
    repeat (8) @(posedge mclk_in);
    // Bypass divider, every source code, Q at both ends
    for (int i = 0; i < 4; i++)
    begin
      c = base;
      c.q = (i == 0) ? 5'd2 : (i == 1) ? 5'd17 : 5'(rnd(2, 17));
      run_test(8'(i << 6), c, 3000);
      check_cnt("bypass_mclk", scale(e[(i == 3) ? 0 : i], 2, c.q), cnt[0]);
    end
    $display("test bypass done");
    // Loop multiplier with random J.D, R, P on both loop sources
    for (int i = 0; i < 4; i++)
    begin
      c = base;
      c.pll_en = 1'b1;
      c.j = (i == 0) ? 6'd63 : (i == 1) ? 6'd7 : (i == 2) ? 6'(rnd(4, 11)) : 6'(rnd(4, 55));
      c.d = (i == 0) ? 14'd9999 : (i == 1) ? 14'd5264 : (i == 2) ? 14'(rnd(1, 9999)) : 14'd0;
      c.r = (i == 3) ? 5'(rnd(1, 2)) : 5'd1;
      c.p = 4'(rnd(4, 8));
      run_test((i == 3) ? 8'h10 : 8'((i % 2) << 5), c, 3000);
      check_cnt("loop_mclk", scale(e[(i == 1) ? 2 : 0], (c.j * 10000 + c.d) * c.r, 80000 * c.p), cnt[0]);
    end
    $display("test loop done");
    // Reference rate and converter rates, single and dual
    for (int i = 0; i < 2; i++)
    begin
      c = base;
      c.pll_en = 1'b1;
      c.j = 6'd32;
      c.adc_half = i ? 4'd2 : 4'd3;
      c.adc_dual = 1'(i);
      c.dac_half = i ? 4'd7 : 4'd12;
      c.dac_dual = 1'(1 - i);
      run_test(8'h00, c, 12000);
      mc = scale(e[0], 32, 8);
      fs = mc / 256;
      check_cnt("conv_mclk", mc, cnt[0]);
      check_cnt("fsref", fs, cnt[1]);
      check_cnt("adc_rate", scale(fs, c.adc_dual ? 4 : 2, c.adc_half), cnt[2]);
      check_cnt("dac_rate", scale(fs, c.dac_dual ? 4 : 2, c.dac_half), cnt[3]);
    end
    $display("test rates done");
    // Clock out from the divider source, every M
    for (int i = 0; i < 4; i++)
    begin
      c = base;
      c.clkout_mux = 1'b1;
      c.clkout_en = 1'b1;
      c.pll_en = 1'(rnd(0, 1));
      c.m_sel = 2'(i);
      c.n = (i == 0) ? 5'd2 : 5'(rnd(2, 17));
      run_test(8'(((i + 1) % 3) << 6), c, 3000);
      check_cnt("clkout_div", scale(e[(i + 1) % 3], 2, (1 << i) * c.n), cnt[4]);
    end
    $display("test clkout_div done");
    // Converters down: second pin through the loop, then loop off
    for (int i = 0; i < 2; i++)
    begin
      c = base;
      c.conv_pd = 1'b1;
      c.pll_en = 1'(1 - i);
      c.clkout_en = 1'(1 - i);
      c.j = 6'd8;
      c.p = 4'd4;
      c.m_sel = 2'd1;
      run_test(8'h10, c, 3000);
      check_cnt("conv_off", 0, cnt[0]);
      check_cnt("clkout_loop", i ? 0 : scale(e[1], 16, 16), cnt[4]);
    end
    $display("test passthrough done");
    wrap_up();
  end
endmodule : acg_clock_gen_tb
